// ==== src/cpu_doze_clock_throttle.sv ====
// Doze stop-clock throttle with two inactivity timers and APB registers
//
// Summary of operation
// - First timer codes 0..7 select 2,4,8,32,128,512 ms, 2 s, 8 s.
// - First timer expiry pulses power-management event twenty-seven.
// - Second timer code 000, the reset value, means no delay.
// - Second timer code 010 selects a 4 ms timeout.
// - Rate 000 no modulation; others set high time fractions 3/4..1/64.
// - High time is the unasserted part of each 32 kHz period.
// - Control select 0 hardware timer Doze, 1 software Doze, timers off.
// - Doze type 0 modulates stop-clock, 1 holds it asserted.
// - Hardware mode enters Doze and modulates when a timer expires.
// - Enabled wake event restores full speed and reloads its timer.
// - Reload-select bit picks first timer at 0, second at 1.
// - Bank select 1 swaps first reload register to PCI set, reset 03h.
// - Writing 1 to start starts software Doze if qualified; 0 ignored.
// - Start bit reads timer status: 1 expired, 0 counting.
// - After software Doze wake, core runs until start written again.
// - SMI recognition bit lets an SMI exit Doze; else SMI ignored.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
`include "cpu_doze_clock_throttle_map.svh"

module cpu_doze_clock_throttle #(
	parameter int MS_TICK_CYCLES = `DZ_MS_CYCLES
) (
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire doze_pkg::wake_in_type WAKE,
	input wire logic SMI,
	output logic CPU_STOP_CLOCK_N,
	output logic PM_EVENT_TWENTY_SEVEN
);
	import doze_pkg::*;
	localparam logic [10:0] THR_CYC = 11'(`DZ_THR_CYCLES);
	localparam logic [15:0] MS_CYC = 16'(MS_TICK_CYCLES);

	// ==========================================
	// Decode helpers
	// True when the address is the aligned word of the given index
	function automatic logic hit(input logic [11:0] a,
		input logic [7:0] idx);
		hit = (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
			(a[9:2] == idx);
	endfunction : hit
	// First timer timeout in ms
	function automatic logic [13:0] t0_ms(input logic [2:0] c);
		case (c)
			3'h0: t0_ms = 14'd2;
			3'h1: t0_ms = 14'd4;
			3'h2: t0_ms = 14'd8;
			3'h3: t0_ms = 14'd32;
			3'h4: t0_ms = 14'd128;
			3'h5: t0_ms = 14'd512;
			3'h6: t0_ms = 14'd2000;
			default: t0_ms = 14'd8000;
		endcase
	endfunction : t0_ms
	// Second timer timeout in ms, zero meaning no delay
	function automatic logic [13:0] t1_ms(input logic [2:0] c);
		case (c)
			3'h0: t1_ms = 14'd0;
			3'h1: t1_ms = 14'd1;
			3'h2: t1_ms = 14'd4;
			3'h3: t1_ms = 14'd16;
			3'h4: t1_ms = 14'd64;
			3'h5: t1_ms = 14'd256;
			3'h6: t1_ms = 14'd1000;
			default: t1_ms = 14'd4000;
		endcase
	endfunction : t1_ms
	// High (unasserted) cycles within one throttle period
	function automatic logic [10:0] hi_cyc(input logic [2:0] r);
		case (r)
			3'h1: hi_cyc = THR_CYC - (THR_CYC >> 2);
			3'h2: hi_cyc = THR_CYC >> 1;
			3'h3: hi_cyc = THR_CYC >> 2;
			3'h4: hi_cyc = THR_CYC >> 3;
			3'h5: hi_cyc = THR_CYC >> 4;
			3'h6: hi_cyc = THR_CYC >> 5;
			3'h7: hi_cyc = THR_CYC >> 6;
			default: hi_cyc = THR_CYC;
		endcase
	endfunction : hi_cyc

	// ==========================================
	// Register storage
	logic [7:0] qual_reg;
	logic [7:0] tctl_reg;
	logic [7:0] pmu4_reg;
	logic [7:0] wake_reg;
	logic [7:0] type_reg;
	logic [7:0] rld_acc_reg;
	logic [7:0] rld_alt_reg;
	logic [7:0] rld_lo_reg;
	logic [7:0] rld_hi_reg;
	logic [7:0] t1ctl_reg;
	logic [7:0] bank_reg;
	logic [31:0] rdata_reg;
	logic err_reg;
	logic [7:0] rd_value;
	logic mapped;
	logic wr_en;
	logic start_wr;
	logic [7:0] wd;
	doze_state_type state_reg;
	doze_state_type state_next;
	logic [1:0] exp_reg;
	logic [1:0] reload;
	logic [13:0] limit [2];
	logic [15:0] ms_cnt_reg;
	logic ms_tick;
	logic [10:0] per_cnt_reg;
	logic stop_n_next;
	logic pm_reg;

	// Zero wait state slave; data and error are latched at setup
	assign PREADY = 1'b1;
	assign PRDATA = rdata_reg;
	assign PSLVERR = err_reg;
	assign wr_en = PSEL & PENABLE & PWRITE & ~err_reg;
	assign wd = PWDATA[7:0];
	assign start_wr = wr_en & hit(PADDR, `DZ_IDX_START) &
		wd[`DZ_START_BIT];

	// ==========================================
	// Read mux and address map
	always_comb begin
		rd_value = 8'h00;
		mapped = 1'b1;
		if (hit(PADDR, `DZ_IDX_SW_QUAL)) begin
			rd_value = qual_reg & `DZ_QUAL_MASK;
		end else if (hit(PADDR, `DZ_IDX_TIMER_CTL)) begin
			rd_value = tctl_reg;
		end else if (hit(PADDR, `DZ_IDX_START)) begin
			rd_value = pmu4_reg;
			rd_value[`DZ_START_BIT] = |exp_reg;
		end else if (hit(PADDR, `DZ_IDX_WAKE)) begin
			rd_value = wake_reg;
		end else if (hit(PADDR, `DZ_IDX_TYPE)) begin
			rd_value = type_reg;
		end else if (hit(PADDR, `DZ_IDX_RLD_ACC)) begin
			if (bank_reg[`DZ_BANK_BIT]) begin
				rd_value = rld_alt_reg & `DZ_ALT_MASK;
			end else begin
				rd_value = rld_acc_reg;
			end
		end else if (hit(PADDR, `DZ_IDX_RLD_IRQ_LO)) begin
			rd_value = rld_lo_reg;
		end else if (hit(PADDR, `DZ_IDX_RLD_IRQ_HI)) begin
			rd_value = rld_hi_reg;
		end else if (hit(PADDR, `DZ_IDX_TIMER1)) begin
			rd_value = t1ctl_reg;
		end else if (hit(PADDR, `DZ_IDX_BANK)) begin
			rd_value = bank_reg & `DZ_BANK_MASK;
		end else begin
			mapped = 1'b0;
		end
	end

	// Answer captured in the setup cycle, shown in the access cycle
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			rdata_reg <= 32'h0000_0000;
			err_reg <= 1'b0;
		end else if (PSEL && !PENABLE) begin
			rdata_reg <= {24'h00_0000, PWRITE ? 8'h00 : rd_value};
			err_reg <= ~mapped;
		end
	end

	// Register writes; start bit itself is not stored
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			qual_reg <= `DZ_RST_ZERO;
			tctl_reg <= `DZ_RST_ZERO;
			pmu4_reg <= `DZ_RST_ZERO;
			wake_reg <= `DZ_RST_ZERO;
			type_reg <= `DZ_RST_ZERO;
			rld_acc_reg <= `DZ_RST_RLD_ACC;
			rld_alt_reg <= `DZ_RST_RLD_ALT;
			rld_lo_reg <= `DZ_RST_ZERO;
			rld_hi_reg <= `DZ_RST_ZERO;
			t1ctl_reg <= `DZ_RST_ZERO;
			bank_reg <= `DZ_RST_ZERO;
		end else if (wr_en) begin
			if (hit(PADDR, `DZ_IDX_SW_QUAL)) begin
				qual_reg <= wd & `DZ_QUAL_MASK;
			end
			if (hit(PADDR, `DZ_IDX_TIMER_CTL)) begin
				tctl_reg <= wd;
			end
			if (hit(PADDR, `DZ_IDX_START)) begin
				pmu4_reg <= wd & ~(8'h01 << `DZ_START_BIT);
			end
			if (hit(PADDR, `DZ_IDX_WAKE)) begin
				wake_reg <= wd;
			end
			if (hit(PADDR, `DZ_IDX_TYPE)) begin
				type_reg <= wd;
			end
			// Bank select steers which set the write lands in
			if (hit(PADDR, `DZ_IDX_RLD_ACC)) begin
				if (bank_reg[`DZ_BANK_BIT]) begin
					rld_alt_reg <= wd & `DZ_ALT_MASK;
				end else begin
					rld_acc_reg <= wd;
				end
			end
			if (hit(PADDR, `DZ_IDX_RLD_IRQ_LO)) begin
				rld_lo_reg <= wd;
			end
			if (hit(PADDR, `DZ_IDX_RLD_IRQ_HI)) begin
				rld_hi_reg <= wd;
			end
			if (hit(PADDR, `DZ_IDX_TIMER1)) begin
				t1ctl_reg <= wd;
			end
			if (hit(PADDR, `DZ_IDX_BANK)) begin
				bank_reg <= wd & `DZ_BANK_MASK;
			end
		end
	end

	// ==========================================
	// Wake events and their timer assignment
	logic acc_en;
	logic irq_en;
	logic smi_wake;
	logic [12:0] acc_ev;
	logic [12:0] acc_sel;
	logic [14:0] irq_ev;
	logic [14:0] irq_sel;
	logic [27:0] ev;
	logic [27:0] sel;
	logic wake;
	logic hw_mode;

	assign hw_mode = ~tctl_reg[`DZ_CTL_SEL_BIT];
	assign acc_en = tctl_reg[`DZ_ACC_EN_BIT];
	assign irq_en = wake_reg[`DZ_IRQ_ALL_BIT];
	// SMI only wakes when recognised during stop-clock
	assign smi_wake = SMI & wake_reg[`DZ_SMI_BIT];
	assign acc_ev = {WAKE.display_access_event,
		WAKE.keyboard_access_event, WAKE.floppy_access_event,
		WAKE.hard_disk_access_event, WAKE.serial_port_access_event,
		WAKE.printer_port_access_event,
		WAKE.generic_decode_one_event,
		WAKE.generic_decode_two_event,
		~WAKE.pci_request_line_n, ~WAKE.clock_run_line_n,
		WAKE.generic_decode_five_event,
		WAKE.generic_decode_six_event, WAKE.pci_bus_activity};
	assign acc_sel = {rld_acc_reg, rld_alt_reg[6], rld_alt_reg[5],
		rld_alt_reg[1], rld_alt_reg[0], rld_hi_reg[7]};
	assign irq_ev = {WAKE.irq_line[8:3], WAKE.irq_line[1:0],
		WAKE.irq_line[15:9]};
	assign irq_sel = {rld_lo_reg, rld_hi_reg[6:0]};
	assign ev = {acc_ev & {13{acc_en}}, irq_ev & {15{irq_en}}};
	assign sel = {acc_sel, irq_sel};
	// A recognised SMI always reloads the first timer
	assign reload[0] = (|(ev & ~sel)) | smi_wake;
	assign reload[1] = |(ev & sel);
	assign wake = |reload;

	// ==========================================
	// Millisecond tick shared by both timers
	assign ms_tick = (ms_cnt_reg == MS_CYC - 16'h0001);
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			ms_cnt_reg <= 16'h0000;
		end else if (ms_tick) begin
			ms_cnt_reg <= 16'h0000;
		end else begin
			ms_cnt_reg <= ms_cnt_reg + 16'h0001;
		end
	end
	assign limit[0] = t0_ms(tctl_reg[`DZ_TSEL_LSB +: 3]);
	assign limit[1] = t1_ms(t1ctl_reg[`DZ_TSEL_LSB +: 3]);

	// ==========================================
	// Inactivity timers; held cleared in software mode
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_timer
			logic [13:0] cnt_reg;
			always_ff @(posedge CLOCK or negedge RESETN) begin
				if (!RESETN) begin
					cnt_reg <= 14'h0000;
					exp_reg[gi] <= 1'b0;
				end else if (!hw_mode || reload[gi]) begin
					cnt_reg <= 14'h0000;
					exp_reg[gi] <= 1'b0;
				end else if (!exp_reg[gi]) begin
					// A zero limit expires at once
					if (cnt_reg >= limit[gi]) begin
						exp_reg[gi] <= 1'b1;
					end else if (ms_tick) begin
						cnt_reg <= cnt_reg + 14'h0001;
					end
				end
			end
		end
	endgenerate

	// Event twenty-seven pulses once on first timer expiry
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			pm_reg <= 1'b0;
		end else begin
			pm_reg <= hw_mode && !reload[0] && !exp_reg[0] &&
				(g_timer[0].cnt_reg >= limit[0]);
		end
	end
	assign PM_EVENT_TWENTY_SEVEN = pm_reg;

	// ==========================================
	// Doze state machine
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (hw_mode && (|exp_reg) && !wake) begin
					state_next = ST_HW_DOZE;
				end else if (!hw_mode && start_wr && !wake &&
					qual_reg[`DZ_QUAL_BIT]) begin
					state_next = ST_SW_DOZE;
				end
			end
			ST_HW_DOZE: begin
				if (wake || !hw_mode) begin
					state_next = ST_RUN;
				end
			end
			ST_SW_DOZE: begin
				// Stays at full speed until the next start write
				if (wake) begin
					state_next = ST_RUN;
				end
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
	end

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			state_reg <= ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================
	// Throttle period counter, free running at 32 kHz
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			per_cnt_reg <= 11'h000;
		end else if (per_cnt_reg == THR_CYC - 11'h001) begin
			per_cnt_reg <= 11'h000;
		end else begin
			per_cnt_reg <= per_cnt_reg + 11'h001;
		end
	end

	// Stop-clock output; low means asserted to the CPU
	always_comb begin
		// Rate 000 in modulate type falls through and stays high
		stop_n_next = 1'b1;
		if (state_next != ST_RUN) begin
			if (type_reg[`DZ_TYPE_BIT]) begin
				stop_n_next = 1'b0;
			end else if (tctl_reg[`DZ_RATE_LSB +: 3] != 3'h0) begin
				stop_n_next = per_cnt_reg <
					hi_cyc(tctl_reg[`DZ_RATE_LSB +: 3]);
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			CPU_STOP_CLOCK_N <= 1'b1;
		end else begin
			CPU_STOP_CLOCK_N <= stop_n_next;
		end
	end
endmodule : cpu_doze_clock_throttle

// ==== src/cpu_doze_clock_throttle_map.svh ====
// Register indexes, field positions, reset values and timing counts
`ifndef CPU_DOZE_CLOCK_THROTTLE_MAP_SVH
`define CPU_DOZE_CLOCK_THROTTLE_MAP_SVH
// ==========================================
// Register indexes (byte address = 4 * index)
`define DZ_IDX_SW_QUAL 8'h40
`define DZ_IDX_TIMER_CTL 8'h41
`define DZ_IDX_START 8'h50
`define DZ_IDX_WAKE 8'h65
`define DZ_IDX_TYPE 8'h66
`define DZ_IDX_RLD_ACC 8'h76
`define DZ_IDX_RLD_IRQ_LO 8'h77
`define DZ_IDX_RLD_IRQ_HI 8'h78
`define DZ_IDX_TIMER1 8'h79
`define DZ_IDX_BANK 8'hae
// ==========================================
// Reset values
`define DZ_RST_ZERO 8'h00
`define DZ_RST_RLD_ACC 8'h0f
`define DZ_RST_RLD_ALT 8'h03
// ==========================================
// Field positions and masks
`define DZ_TSEL_LSB 5
`define DZ_RATE_LSB 2
`define DZ_ACC_EN_BIT 1
`define DZ_CTL_SEL_BIT 0
`define DZ_START_BIT 3
`define DZ_SMI_BIT 4
`define DZ_IRQ_ALL_BIT 7
`define DZ_TYPE_BIT 5
`define DZ_BANK_BIT 7
`define DZ_QUAL_BIT 0
`define DZ_ALT_MASK 8'h63
`define DZ_QUAL_MASK 8'h01
`define DZ_BANK_MASK 8'h80
// ==========================================
// Timing
`define DZ_CLK_PERIOD_NS 20
`define DZ_MS_TIME_NS 1000000
`define DZ_MS_CYCLES (`DZ_MS_TIME_NS / `DZ_CLK_PERIOD_NS)
`define DZ_THR_FREQ_HZ 32000
`define DZ_THR_PERIOD_NS (1000000000 / `DZ_THR_FREQ_HZ)
`define DZ_THR_CYCLES (`DZ_THR_PERIOD_NS / `DZ_CLK_PERIOD_NS)
`endif

// ==== src/doze_pkg.sv ====
// Types shared by the doze clock throttle
package doze_pkg;
	// ==========================================
	// Wake and reload event inputs
	typedef struct packed {
		logic display_access_event;
		logic keyboard_access_event;
		logic floppy_access_event;
		logic hard_disk_access_event;
		logic serial_port_access_event;
		logic printer_port_access_event;
		logic generic_decode_one_event;
		logic generic_decode_two_event;
		logic generic_decode_five_event;
		logic generic_decode_six_event;
		logic pci_request_line_n;
		logic clock_run_line_n;
		logic pci_bus_activity;
		logic [15:0] irq_line;
	} wake_in_type;
	// ==========================================
	// Doze state
	typedef enum logic [1:0] {
		ST_RUN,
		ST_HW_DOZE,
		ST_SW_DOZE
	} doze_state_type;
endpackage : doze_pkg

// ==== test/cpu_doze_clock_throttle_chk.sv ====
// Checker: doze entry, wake and throttle properties at the block's ports
`timescale 1ns/10ps
module cpu_doze_clock_throttle_chk
	import doze_pkg::*;
#(
	parameter int MS_TICK_CYCLES = 10
) (
	input wire logic CLOCK,
	input wire logic RESETN,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire doze_pkg::wake_in_type WAKE,
	input wire logic SMI,
	input wire logic CPU_STOP_CLOCK_N,
	input wire logic PM_EVENT_TWENTY_SEVEN
);
	localparam wake_in_type IDLE = 29'h0006_0000;
	logic [7:0] ctl_reg, type_reg, wake_reg;
	logic qual_reg, calm_reg, wr;
	assign wr = PSEL && PENABLE && PWRITE;
	// ==========================================
	// Shadow copies of control bytes, so causes are visible here
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			ctl_reg <= 8'h00;
			type_reg <= 8'h00;
			wake_reg <= 8'h00;
			qual_reg <= 1'b0;
		end else if (wr) begin
			if (PADDR == 12'h104) ctl_reg <= PWDATA[7:0];
			if (PADDR == 12'h198) type_reg <= PWDATA[7:0];
			if (PADDR == 12'h194) wake_reg <= PWDATA[7:0];
			if (PADDR == 12'h100) qual_reg <= PWDATA[0];
		end
	end
	// No-throttle setting one cycle old; output is computed a cycle late
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) calm_reg <= 1'b1;
		else calm_reg <= ctl_reg[4:2] == 3'h0 && !type_reg[5];
	end
	// ==========================================
	// Properties
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESETN);
	sequence acc_s;
		PSEL && PENABLE;
	endsequence
	sequence start_s;
		wr && PADDR == 12'h140 && PWDATA[3];
	endsequence
	a_pm_one_cycle: assert property (PM_EVENT_TWENTY_SEVEN |=>
		!PM_EVENT_TWENTY_SEVEN) else $error("event pulse too long");
	a_pm_hw_only: assert property (PM_EVENT_TWENTY_SEVEN |->
		!$past(ctl_reg[0], 2)) else $error("event in software mode");
	a_access_wake: assert property (ctl_reg[1] &&
		WAKE.keyboard_access_event |=> CPU_STOP_CLOCK_N)
		else $error("access did not wake");
	// Line 2 is the cascade input and never reloads a timer
	a_irq_wake: assert property (wake_reg[7] &&
		|(WAKE.irq_line & 16'hfffb) |=> CPU_STOP_CLOCK_N)
		else $error("irq did not wake");
	a_smi_wake: assert property (wake_reg[4] && SMI |=>
		CPU_STOP_CLOCK_N) else $error("smi did not wake");
	a_no_throttle: assert property (calm_reg && ctl_reg[4:2] == 3'h0 &&
		!type_reg[5] |-> CPU_STOP_CLOCK_N) else $error("throttled");
	a_start_keep: assert property (start_s ##0 (qual_reg && ctl_reg[0]
		&& type_reg[5] && WAKE == IDLE && !SMI) |=> !CPU_STOP_CLOCK_N)
		else $error("start did not stop clock");
	// Steady keep type: a high output can only mean the run state
	a_sw_stays_run: assert property (ctl_reg[0] && type_reg[5] &&
		$past(type_reg[5]) && CPU_STOP_CLOCK_N &&
		!(wr && PADDR == 12'h140 && PWDATA[3]) |=> CPU_STOP_CLOCK_N)
		else $error("left full speed without start");
	a_err_unmapped: assert property (acc_s ##0 PADDR[1:0] != 2'h0 |->
		PSLVERR) else $error("misaligned access not refused");
endmodule : cpu_doze_clock_throttle_chk
bind cpu_doze_clock_throttle cpu_doze_clock_throttle_chk #(
	.MS_TICK_CYCLES(MS_TICK_CYCLES)
) chk (.CLOCK(CLOCK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
	.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .WAKE(WAKE), .SMI(SMI),
	.CPU_STOP_CLOCK_N(CPU_STOP_CLOCK_N),
	.PM_EVENT_TWENTY_SEVEN(PM_EVENT_TWENTY_SEVEN));

// ==== test/cpu_doze_clock_throttle_test.sv ====
// Testbench: registers, inactivity timers, throttle, doze entry and exit
`timescale 1ns/10ps
module cpu_doze_clock_throttle_test;
	import doze_pkg::*;
	localparam int MS = 4;
	localparam int PER = 1562;
	localparam wake_in_type IDLE = 29'h0006_0000;
	logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, err, smi = 0, stop_n, pm, clr = 1;
	wake_in_type wake = IDLE, w;
	int miscompares = 0, n_checks = 0, stopped, n;
	int ms_tab[8] = '{2, 4, 8, 32, 128, 512, 2000, 8000};
	logic [11:0] ra[10] = '{12'h104, 12'h140, 12'h194, 12'h198, 12'h1d8,
		12'h1dc, 12'h1e0, 12'h1e4, 12'h100, 12'h2b8};
	cpu_doze_clock_throttle #(.MS_TICK_CYCLES(MS)) dut (.CLOCK(clock),
		.RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .WAKE(wake), .SMI(smi),
		.CPU_STOP_CLOCK_N(stop_n), .PM_EVENT_TWENTY_SEVEN(pm));
	cpu_stop_clock_model cpu (.clock(clock), .clear(clr),
		.stop_clock_n(stop_n), .stopped(stopped));
	// ==========================================
	// Clock and hang guard
	always #10 clock = ~clock;
	initial begin
		repeat (95000) @(posedge clock);
		miscompares++;
		end_sim();
	end
	// ==========================================
	// Helpers
	task end_sim;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : end_sim
	task chk_val(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_val
	task chk_near(input int got, input int exp, input int tol);
		n_checks++;
		if (got < exp - tol || got > exp + tol) begin
			miscompares++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_near
	// One APB transfer; zero-wait answers are still waited for
	task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(posedge clock);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clock);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			miscompares++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task rdchk(input logic [11:0] a, input logic [7:0] exp);
		apb(0, a, 8'h00);
		chk_val(rd, {24'h000000, exp});
	endtask : rdchk
	task pulse(input wake_in_type v, input logic s);
		@(posedge clock);
		wake <= v;
		smi <= s;
		@(posedge clock);
		wake <= IDLE;
		smi <= 0;
	endtask : pulse
	// Stopped cycles over one whole throttle period
	task measure(input int exp);
		@(posedge clock);
		clr <= 1;
		@(posedge clock);
		clr <= 0;
		repeat (PER) @(posedge clock);
		@(negedge clock);
		chk_val(stopped, exp);
	endtask : measure
	function int low_exp(input int r);
		if (r == 0) return 0;
		return PER - (r == 1 ? PER - (PER >> 2) : PER >> (r - 1));
	endfunction : low_exp
	task stop_is(input logic v);
		@(negedge clock);
		chk_val({31'h0, stop_n}, {31'h0, v});
	endtask : stop_is
	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(32'h9f61));
		repeat (20) @(posedge clock);
		resetn <= 1;
		for (int i = 0; i < 10; i++)
			rdchk(ra[i], i == 4 ? 8'h0f : i == 1 ? 8'h08 : 8'h00);
		apb(0, 12'h3fc, 8'h00);
		chk_val({rd[30:0], err}, 32'h1);
		apb(1, 12'h105, 8'hff);
		chk_val({31'h0, err}, 32'h1);
		for (int i = 0; i < 2; i++) begin
			w = 29'($urandom);
			apb(1, ra[5 + i], w[7:0]);
			rdchk(ra[5 + i], w[7:0]);
		end
		apb(1, 12'h2b8, 8'h80);
		rdchk(12'h1d8, 8'h03);
		apb(1, 12'h1d8, 8'hff);
		rdchk(12'h1d8, 8'h63);
		apb(1, 12'h2b8, 8'h00);
		rdchk(12'h1d8, 8'h0f);
		// Each timeout code, measured from an access reload
		apb(1, 12'h1e4, 8'he0);
		w = IDLE;
		w.keyboard_access_event = 1;
		for (int c = 0; c < 8; c++) begin
			apb(1, 12'h104, {c[2:0], 5'b00010});
			pulse(w, 0);
			n = 0;
			while (pm !== 1'b1 && n < ms_tab[c] * MS + 60) begin
				@(negedge clock);
				n++;
			end
			chk_near(n, ms_tab[c] * MS, MS + 3);
		end
		for (int r = 0; r < 8; r++) begin
			apb(1, 12'h104, {3'b111, r[2:0], 2'b10});
			measure(low_exp(r));
		end
		apb(1, 12'h198, 8'h20);
		measure(PER);
		// Second timer status through the start bit
		apb(1, 12'h1d8, 8'h8f);
		apb(1, 12'h1e4, 8'h40);
		w.display_access_event = 1;
		pulse(w, 0);
		rdchk(12'h140, 8'h00);
		repeat (5 * MS + 2) @(posedge clock);
		rdchk(12'h140, 8'h08);
		apb(1, 12'h1e4, 8'h00);
		pulse(w, 0);
		rdchk(12'h140, 8'h08);
		// Software doze entry and its wake sources
		apb(1, 12'h194, 8'h90);
		apb(1, 12'h100, 8'h01);
		apb(1, 12'h104, 8'heb);
		apb(1, 12'h140, 8'h08);
		stop_is(0);
		rdchk(12'h140, 8'h00);
		w = IDLE;
		// Line 2 cascades and has no reload select, so it is never drawn
		n = $urandom % 15;
		w.irq_line = 16'h0001 << (n < 2 ? n : n + 1);
		pulse(w, 0);
		measure(0);
		apb(1, 12'h140, 8'h00);
		stop_is(1);
		apb(1, 12'h140, 8'h08);
		pulse(IDLE, 1);
		stop_is(1);
		apb(1, 12'h194, 8'h80);
		apb(1, 12'h140, 8'h08);
		pulse(IDLE, 1);
		stop_is(0);
		w = IDLE;
		w.keyboard_access_event = 1;
		pulse(w, 0);
		stop_is(1);
		apb(1, 12'h100, 8'h00);
		apb(1, 12'h140, 8'h08);
		stop_is(1);
		end_sim();
	end
endmodule : cpu_doze_clock_throttle_test

// ==== test/cpu_stop_clock_model.sv ====
// Processor model: counts the cycles its core clock is held stopped
`timescale 1ns/10ps
module cpu_stop_clock_model (
	input wire logic clock,
	input wire logic clear,
	input wire logic stop_clock_n,
	output int stopped
);
	// ==========================================
	// A stopped core does no work; the count is the lost cycles
	always @(posedge clock) begin
		if (clear) stopped <= 0;
		else if (stop_clock_n === 1'b0) stopped <= stopped + 1;
	end
endmodule : cpu_stop_clock_model
